/* File: shared/xfe_map.svh */
// Register offsets, field positions, reset values and opcode patterns of the xor/extension core
//Function
//- With the bank-access bit at 0 and the extension enabled, a file operand of 95 (5Fh) or less is an offset indexed from pointer two.
//- The core carries the base instruction set and optionally eight extra instructions that strengthen indirect and indexed addressing;
//  here only xor-with-file and add/subtract-literal on a pointer, each with a pointer-two return variant, are built.
//- The extension is on in an unprogrammed part and is switched on or off by a configuration bit set before run time; here CTRL bit 0 sets it at run time.
//- Every extended instruction is a literal operation that changes a pointer register or uses one as an index base.
//- Add-literal and subtract-literal on a pointer each have a variant fixed to pointer two that returns from the subroutine after it runs.
//- With the extension on, indexed literal offset addressing also applies to standard byte- and bit-oriented instructions.
//- Opcode fields are read the same way for base and extended instruction words.
//- The add-and-return variant adds a 6-bit literal to pointer two and then loads the program counter from the return stack top.
`ifndef XFE_MAP_SVH
`define XFE_MAP_SVH
`define XFE_REG_CTRL 8'h00
`define XFE_REG_INSTR 8'h04
`define XFE_REG_WREG 8'h08
`define XFE_REG_STATUS 8'h0C
`define XFE_REG_BANK 8'h10
`define XFE_REG_PTR0 8'h14
`define XFE_REG_PTR1 8'h18
`define XFE_REG_PTR2 8'h1C
`define XFE_REG_PC 8'h20
`define XFE_REG_RSTACK 8'h24
`define XFE_REG_MADDR 8'h28
`define XFE_REG_MDATA 8'h2C
`define XFE_CTRL_EXT_BIT 0
`define XFE_CTRL_RESET 1'b1
`define XFE_STAT_N_BIT 0
`define XFE_STAT_Z_BIT 1
`define XFE_STAT_BUSY_BIT 2
`define XFE_STAT_ILL_BIT 3
`define XFE_OPC_XOR_FILE 6'h06
`define XFE_OPC_EXT_PTR 7'h74
`define XFE_PTR_FIELD_TWO 2'h3
`define XFE_PTR_TWO 2'h2
`define XFE_INDEX_LIMIT 8'h5F
`define XFE_ACCESS_HIGH 4'hF
`define XFE_ACCESS_LOW 4'h0
`define XFE_LAST_PHASE 2'h3
`define XFE_PC_STEP 21'h000002
`define XFE_RESP_OKAY 2'h0
`define XFE_RESP_SLVERR 2'h2
`endif

/* File: shared/xfe_pkg.sv */
// Types shared by the xor/extension core and its decoder
package xfe_pkg;
  typedef enum logic [2:0] {
    XFE_OP_XOR_FILE,
    XFE_OP_ADD_PTR,
    XFE_OP_SUB_PTR,
    XFE_OP_ILLEGAL
  } xfe_op_t;
  typedef enum logic [2:0] {
    XFE_ST_IDLE,
    XFE_ST_DECODE,
    XFE_ST_READ,
    XFE_ST_PROCESS,
    XFE_ST_WRITE,
    XFE_ST_EXTRA
  } xfe_state_t;
endpackage

/* File: src/xfe_core.sv */
// Xor-with-file and pointer-literal execution core behind an AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "xfe_map.svh"
module xfe_core import xfe_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int MEM_AW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Bus group
  logic awFull, next_awFull, wFull, next_wFull;
  logic [ADDR_W-1:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic awReady, next_awReady, wReady, next_wReady;
  logic bValid, next_bValid, arReady, next_arReady, rValid, next_rValid;
  logic [1:0] bResp, next_bResp, rResp, next_rResp;
  logic [31:0] rData, next_rData;
  // Core group
  xfe_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [15:0] instr, next_instr;
  xfe_op_t opQ, next_opQ;
  logic destQ, next_destQ, retQ, next_retQ;
  logic [1:0] selQ, next_selQ;
  logic [5:0] litQ, next_litQ;
  logic [11:0] addrQ, next_addrQ, ptrQ, next_ptrQ;
  logic [7:0] opnd, next_opnd, res, next_res, wreg, next_wreg;
  logic [3:0] bankSel, next_bankSel;
  logic [11:0] filePtr [4];
  logic [11:0] next_filePtr [4];
  logic [20:0] pc, next_pc, retTop, next_retTop;
  logic flagN, next_flagN, flagZ, next_flagZ, illegal, next_illegal;
  logic extEnable, next_extEnable;
  logic [11:0] memAddr, next_memAddr;
  logic [7:0] mem [2**MEM_AW];
  // Decoder outputs
  xfe_op_t decOp;
  logic decDest, decRet;
  logic [1:0] decSel;
  logic [5:0] decLit;
  logic [11:0] decAddr;
  // Bus write command presented to the core this cycle
  logic busCommit, busy, busRefused, memWe;
  logic [32:0] wrCur;
  logic [31:0] wrVal;
  logic [MEM_AW-1:0] memWa;
  logic [7:0] memWd;
  logic [32:0] rdHit;

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Returns {hit, value} for a register offset
  function automatic logic [32:0] regRead(input logic [ADDR_W-1:0] a);
    logic [32:0] r;
    r = 33'h000000000;
    if (a == `XFE_REG_CTRL) begin
      r = {1'b1, 31'h00000000, extEnable};
    end else if (a == `XFE_REG_INSTR) begin
      r = {1'b1, 16'h0000, instr};
    end else if (a == `XFE_REG_WREG) begin
      r = {1'b1, 24'h000000, wreg};
    end else if (a == `XFE_REG_STATUS) begin
      r = {1'b1, 28'h0000000, illegal, busy, flagZ, flagN};
    end else if (a == `XFE_REG_BANK) begin
      r = {1'b1, 28'h0000000, bankSel};
    end else if (a == `XFE_REG_PTR0) begin
      r = {1'b1, 20'h00000, filePtr[0]};
    end else if (a == `XFE_REG_PTR1) begin
      r = {1'b1, 20'h00000, filePtr[1]};
    end else if (a == `XFE_REG_PTR2) begin
      r = {1'b1, 20'h00000, filePtr[2]};
    end else if (a == `XFE_REG_PC) begin
      r = {1'b1, 11'h000, pc};
    end else if (a == `XFE_REG_RSTACK) begin
      r = {1'b1, 11'h000, retTop};
    end else if (a == `XFE_REG_MADDR) begin
      r = {1'b1, 20'h00000, memAddr};
    end else if (a == `XFE_REG_MDATA) begin
      r = {1'b1, 24'h000000, mem[memAddr[MEM_AW-1:0]]};
    end
    return r;
  endfunction

  xfe_decode xfe_decode_inst (
    .instr(instr),
    .extEnable(extEnable),
    .bankSelect(bankSel),
    .pointerTwo(filePtr[2]),
    .op(decOp),
    .destFile(decDest),
    .fsrSel(decSel),
    .literal(decLit),
    .doReturn(decRet),
    .effAddr(decAddr)
  );

  assign busy = (state != XFE_ST_IDLE);
  assign rdHit = regRead(s_axi_araddr);
  assign busCommit = awFull && wFull && !bValid;
  assign wrCur = regRead(awAddr);
  assign wrVal = mergeStrb(wrCur[31:0], wData, wStrb);
  // While an instruction runs only the status register may be written, and there only
  // the illegal bit can change, so core and bus meet on that one bit alone
  assign busRefused = !wrCur[32] || (busy && awAddr != `XFE_REG_STATUS);

  always_comb begin
    next_awFull = awFull;
    next_awAddr = awAddr;
    next_wFull = wFull;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (s_axi_awvalid && awReady) begin
      next_awFull = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady) begin
      next_wFull = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (busCommit) begin
      next_awFull = 1'b0;
      next_wFull = 1'b0;
      next_bValid = 1'b1;
      next_bResp = busRefused ? `XFE_RESP_SLVERR : `XFE_RESP_OKAY;
    end else if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
    next_awReady = !next_awFull;
    next_wReady = !next_wFull;
    if (s_axi_arvalid && arReady) begin
      next_rValid = 1'b1;
      next_rData = rdHit[31:0] & {32{rdHit[32]}};
      next_rResp = rdHit[32] ? `XFE_RESP_OKAY : `XFE_RESP_SLVERR;
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
    // One read in flight: the address channel stays shut while data waits
    next_arReady = !next_rValid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awFull <= 1'b0;
      awAddr <= '0;
      wFull <= 1'b0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      awReady <= 1'b0;
      wReady <= 1'b0;
      bValid <= 1'b0;
      bResp <= `XFE_RESP_OKAY;
      arReady <= 1'b0;
      rValid <= 1'b0;
      rData <= 32'h00000000;
      rResp <= `XFE_RESP_OKAY;
    end else if (ce) begin
      awFull <= next_awFull;
      awAddr <= next_awAddr;
      wFull <= next_wFull;
      wData <= next_wData;
      wStrb <= next_wStrb;
      awReady <= next_awReady;
      wReady <= next_wReady;
      bValid <= next_bValid;
      bResp <= next_bResp;
      arReady <= next_arReady;
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  always_comb begin
    logic ok;
    ok = busCommit && !busRefused;
    next_state = state;
    next_phase = phase;
    next_instr = instr;
    next_opQ = opQ;
    next_destQ = destQ;
    next_retQ = retQ;
    next_selQ = selQ;
    next_litQ = litQ;
    next_addrQ = addrQ;
    next_ptrQ = ptrQ;
    next_opnd = opnd;
    next_res = res;
    next_wreg = wreg;
    next_bankSel = bankSel;
    next_filePtr = filePtr;
    next_pc = pc;
    next_retTop = retTop;
    next_flagN = flagN;
    next_flagZ = flagZ;
    next_illegal = illegal;
    next_extEnable = extEnable;
    next_memAddr = memAddr;
    if (ok) begin
      if (awAddr == `XFE_REG_CTRL) begin
        // Refused while busy, so the mode only changes between instructions
        next_extEnable = wrVal[`XFE_CTRL_EXT_BIT];
      end else if (awAddr == `XFE_REG_INSTR) begin
        next_instr = wrVal[15:0];
        next_state = XFE_ST_DECODE;
      end else if (awAddr == `XFE_REG_WREG) begin
        next_wreg = wrVal[7:0];
      end else if (awAddr == `XFE_REG_STATUS) begin
        next_flagN = busy ? flagN : wrVal[`XFE_STAT_N_BIT];
        next_flagZ = busy ? flagZ : wrVal[`XFE_STAT_Z_BIT];
        next_illegal = illegal && !(wStrb[0] && wData[`XFE_STAT_ILL_BIT]);
      end else if (awAddr == `XFE_REG_BANK) begin
        next_bankSel = wrVal[3:0];
      end else if (awAddr == `XFE_REG_PTR0) begin
        next_filePtr[0] = wrVal[11:0];
      end else if (awAddr == `XFE_REG_PTR1) begin
        next_filePtr[1] = wrVal[11:0];
      end else if (awAddr == `XFE_REG_PTR2) begin
        next_filePtr[2] = wrVal[11:0];
      end else if (awAddr == `XFE_REG_PC) begin
        next_pc = wrVal[20:0];
      end else if (awAddr == `XFE_REG_RSTACK) begin
        next_retTop = wrVal[20:0];
      end else if (awAddr == `XFE_REG_MADDR) begin
        next_memAddr = wrVal[11:0];
      end
    end
    case (state)
      XFE_ST_IDLE: begin
      end
      XFE_ST_DECODE: begin
        next_opQ = decOp;
        next_destQ = decDest;
        next_retQ = decRet;
        next_selQ = decSel;
        next_litQ = decLit;
        next_addrQ = decAddr;
        next_state = XFE_ST_READ;
      end
      XFE_ST_READ: begin
        next_opnd = mem[addrQ[MEM_AW-1:0]];
        next_ptrQ = filePtr[selQ];
        next_state = XFE_ST_PROCESS;
      end
      XFE_ST_PROCESS: begin
        next_res = wreg ^ opnd;
        next_ptrQ = (opQ == XFE_OP_SUB_PTR) ? ptrQ - {6'h00, litQ} : ptrQ + {6'h00, litQ};
        next_state = XFE_ST_WRITE;
      end
      XFE_ST_WRITE: begin
        next_pc = pc + `XFE_PC_STEP;
        next_state = XFE_ST_IDLE;
        if (opQ == XFE_OP_XOR_FILE) begin
          next_wreg = destQ ? wreg : res;
          next_flagN = res[7];
          next_flagZ = (res == 8'h00);
        end else if (opQ == XFE_OP_ILLEGAL) begin
          // Hardware set wins over a clear in the same cycle
          next_illegal = 1'b1;
        end else begin
          next_filePtr[selQ] = ptrQ;
          if (retQ) begin
            // Return costs a second instruction cycle of four phases
            next_pc = retTop;
            next_phase = 2'h0;
            next_state = XFE_ST_EXTRA;
          end
        end
      end
      XFE_ST_EXTRA: begin
        next_phase = phase + 2'h1;
        if (phase == `XFE_LAST_PHASE) begin
          next_state = XFE_ST_IDLE;
        end
      end
      default: begin
        next_state = XFE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= XFE_ST_IDLE;
      phase <= 2'h0;
      instr <= 16'h0000;
      opQ <= XFE_OP_ILLEGAL;
      destQ <= 1'b0;
      retQ <= 1'b0;
      selQ <= 2'h0;
      litQ <= 6'h00;
      addrQ <= 12'h000;
      ptrQ <= 12'h000;
      opnd <= 8'h00;
      res <= 8'h00;
      wreg <= 8'h00;
      bankSel <= 4'h0;
      filePtr <= '{default: 12'h000};
      pc <= 21'h000000;
      retTop <= 21'h000000;
      flagN <= 1'b0;
      flagZ <= 1'b0;
      illegal <= 1'b0;
      extEnable <= `XFE_CTRL_RESET;
      memAddr <= 12'h000;
    end else if (ce) begin
      state <= next_state;
      phase <= next_phase;
      instr <= next_instr;
      opQ <= next_opQ;
      destQ <= next_destQ;
      retQ <= next_retQ;
      selQ <= next_selQ;
      litQ <= next_litQ;
      addrQ <= next_addrQ;
      ptrQ <= next_ptrQ;
      opnd <= next_opnd;
      res <= next_res;
      wreg <= next_wreg;
      bankSel <= next_bankSel;
      filePtr <= next_filePtr;
      pc <= next_pc;
      retTop <= next_retTop;
      flagN <= next_flagN;
      flagZ <= next_flagZ;
      illegal <= next_illegal;
      extEnable <= next_extEnable;
      memAddr <= next_memAddr;
    end
  end

  // File store: the xor result lands in the file register when the direction bit is 1
  assign memWe = (state == XFE_ST_WRITE && opQ == XFE_OP_XOR_FILE && destQ) ||
                 (busCommit && !busRefused && awAddr == `XFE_REG_MDATA);
  assign memWa = (state == XFE_ST_WRITE) ? addrQ[MEM_AW-1:0] : memAddr[MEM_AW-1:0];
  assign memWd = (state == XFE_ST_WRITE) ? res : wrVal[7:0];

  always_ff @(posedge clk) begin
    if (ce && memWe) begin
      mem[memWa] <= memWd;
    end
  end

  assign s_axi_awready = awReady;
  assign s_axi_wready = wReady;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = arReady;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;
endmodule
`default_nettype wire

/* File: src/xfe_decode.sv */
// Instruction word decoder: operation class, fields and effective file address
`timescale 1ns/10ps
`default_nettype none
`include "xfe_map.svh"
module xfe_decode import xfe_pkg::*; (
  input wire logic [15:0] instr,
  input wire logic extEnable,
  input wire logic [3:0] bankSelect,
  input wire logic [11:0] pointerTwo,
  output xfe_op_t op,
  output logic destFile,
  output logic [1:0] fsrSel,
  output logic [5:0] literal,
  output logic doReturn,
  output logic [11:0] effAddr
);
  logic [7:0] fileField;
  logic bankAccess;

  // Same field positions for every word: d at 9, a at 8, f at 7:0
  assign fileField = instr[7:0];
  assign bankAccess = instr[8];
  assign destFile = instr[9];
  assign literal = instr[5:0];

  always_comb begin
    op = XFE_OP_ILLEGAL;
    if (instr[15:10] == `XFE_OPC_XOR_FILE) begin
      op = XFE_OP_XOR_FILE;
    end else if (instr[15:9] == `XFE_OPC_EXT_PTR && extEnable) begin
      // Literal ops on a pointer only exist while the extension is on
      op = instr[8] ? XFE_OP_SUB_PTR : XFE_OP_ADD_PTR;
    end
  end

  // Field value 3 selects the pointer-two variant that also returns
  assign doReturn = (instr[7:6] == `XFE_PTR_FIELD_TWO);
  assign fsrSel = doReturn ? `XFE_PTR_TWO : instr[7:6];

  always_comb begin
    if (!bankAccess && extEnable && fileField <= `XFE_INDEX_LIMIT) begin
      effAddr = pointerTwo + {4'h0, fileField};
    end else if (!bankAccess) begin
      effAddr = {(fileField <= `XFE_INDEX_LIMIT) ? `XFE_ACCESS_LOW : `XFE_ACCESS_HIGH, fileField};
    end else begin
      effAddr = {bankSelect, fileField};
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_xfe_core.sv */
// Self-checking bench for the xor/extension core over its register bus
`timescale 1ns/10ps
`default_nettype none
`include "xfe_map.svh"
module tb_xfe_core import xfe_pkg::*;;
  logic clk, rst, ce, awValid, wValid, bReady, arValid, rReady;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [7:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp;
  int failCount, totalChecks;
  integer seed = 32'h2F3F;
  xfe_core xfe_core_inst (.clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic stopTest();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready for the answer is sometimes held back so a waiting response must stand
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic lateAns;
    n = 0;
    lateAns = $random(seed);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= !lateAns;
    do begin
      @(posedge clk);
      n++;
      if (awReady && awValid) awValid <= 1'b0;
      if (wReady && wValid) wValid <= 1'b0;
      if (bValid && !bReady) bReady <= 1'b1;
    end while (!(bValid === 1'b1 && bReady === 1'b1) && n < 200);
    r = bResp;
    bReady <= 1'b0;
    if (n >= 200) failCount++;
  endtask
  task automatic busRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic lateAns;
    n = 0;
    lateAns = $random(seed);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= !lateAns;
    do begin
      @(posedge clk);
      n++;
      if (arReady && arValid) arValid <= 1'b0;
      if (rValid && !rReady) rReady <= 1'b1;
    end while (!(rValid === 1'b1 && rReady === 1'b1) && n < 200);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    if (n >= 200) failCount++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    busWrite(a, d, r);
    check({30'h0, r}, {30'h0, `XFE_RESP_OKAY});
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    busRead(a, d, r);
    check(d, e);
  endtask
  // Polls busy with a bound so a stuck core shows up as a mismatch, not a hang
  task automatic runInstr(input logic [15:0] w);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    wr(`XFE_REG_INSTR, {16'h0000, w});
    do begin
      busRead(`XFE_REG_STATUS, d, r);
      n++;
    end while (d[`XFE_STAT_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20) failCount++;
  endtask
  function automatic logic [11:0] effAddr(logic a, logic ext, logic [7:0] f, logic [3:0] bank,
    logic [11:0] p2);
    if (a) return {bank, f};
    if (ext && f <= 8'h5F) return p2 + {4'h0, f};
    return {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
  endfunction
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [7:0] w, m, f, res;
  logic [11:0] p, ea;
  logic [20:0] retTop, pc;
  logic [5:0] k;
  logic [3:0] bankSel;
  logic ext, a, d;
  int ff, idx;
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    {awAddr, arAddr, wData, wStrb} = {8'h00, 8'h00, 32'h0, 4'hF};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdChk(`XFE_REG_CTRL, 32'h1);
    rdChk(`XFE_REG_PTR2, 32'h0);
    busRead(8'h30, rd, rsp);
    check({rd[29:0], rsp}, {30'h0, `XFE_RESP_SLVERR});
    wr(`XFE_REG_STATUS, 32'h4);
    rdChk(`XFE_REG_STATUS, 32'h0);
    // A return variant keeps the core busy long enough to see a refused write
    wr(`XFE_REG_INSTR, {16'h0000, `XFE_OPC_EXT_PTR, 9'h0C0});
    busWrite(`XFE_REG_WREG, 32'hA5, rsp);
    check({30'h0, rsp}, {30'h0, `XFE_RESP_SLVERR});
    rdChk(`XFE_REG_WREG, 32'h0);
    for (int i = 0; i < 24; i++) begin
      w = $random(seed);
      m = (i == 3) ? w : $random(seed);
      ext = (i < 8) ? i[0] : $random(seed);
      f = (i < 8) ? (i[1] ? 8'h60 : 8'h5F) : $random(seed);
      a = (i < 8) ? i[2] : $random(seed);
      d = $random(seed);
      bankSel = $random(seed);
      p = $random(seed);
      wr(`XFE_REG_CTRL, {31'h0, ext});
      wr(`XFE_REG_BANK, {28'h0, bankSel});
      wr(`XFE_REG_PTR2, {20'h0, p});
      wr(`XFE_REG_WREG, {24'h0, w});
      ea = effAddr(a, ext, f, bankSel, p);
      wr(`XFE_REG_MADDR, {20'h0, ea});
      wr(`XFE_REG_MDATA, {24'h0, m});
      runInstr({`XFE_OPC_XOR_FILE, d, a, f});
      res = w ^ m;
      rdChk(`XFE_REG_WREG, {24'h0, d ? w : res});
      rdChk(`XFE_REG_MDATA, {24'h0, d ? res : m});
      rdChk(`XFE_REG_STATUS, {30'h0, res == 8'h00, res[7]});
    end
    // Every pointer op with the extension on and off; flags preset to spot stray updates
    for (int e = 0; e < 2; e++) begin
      for (int j = 0; j < 8; j++) begin
        ff = j >> 1;
        idx = (ff == 3) ? 2 : ff;
        p = $random(seed);
        k = (j == 0) ? 6'h3F : $random(seed);
        retTop = $random(seed);
        wr(`XFE_REG_CTRL, e);
        wr(`XFE_REG_STATUS, 32'hB);
        wr(`XFE_REG_PTR0 + 8'(idx * 4), {20'h0, p});
        wr(`XFE_REG_RSTACK, {11'h0, retTop});
        busRead(`XFE_REG_PC, rd, rsp);
        pc = rd[20:0];
        runInstr({`XFE_OPC_EXT_PTR, j[0], 2'(ff), k});
        if (e == 1) begin
          rdChk(`XFE_REG_PTR0 + 8'(idx * 4), {20'h0, j[0] ? p - k : p + k});
          rdChk(`XFE_REG_PC, {11'h0, (ff == 3) ? retTop : pc + 21'h2});
          rdChk(`XFE_REG_STATUS, 32'h3);
        end else begin
          rdChk(`XFE_REG_PTR0 + 8'(idx * 4), {20'h0, p});
          rdChk(`XFE_REG_PC, {11'h0, pc + 21'h2});
          rdChk(`XFE_REG_STATUS, 32'hB);
        end
      end
    end
    stopTest();
  end
  initial begin
    repeat (40000) @(posedge clk);
    failCount++;
    stopTest();
  end
endmodule
bind xfe_core xfe_core_checker #(.ADDR_W(ADDR_W)) xfe_core_checker_inst (.clk(clk), .rst(rst),
  .ce(ce), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

/* File: tb/xfe_core_checker.sv */
// Bus-level assertions watching the ports of the xor/extension core
`timescale 1ns/10ps
`default_nettype none
module xfe_core_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Flops hold reset values at the first edge, then the slave opens up
  a_reset_release: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid ##1
    s_axi_awready && s_axi_wready && s_axi_arready) else $error("ready not raised after reset");
  a_aw_taken_drop: assert property (s_axi_awvalid && s_axi_awready && ce |=> !s_axi_awready)
    else $error("awready stayed high after address taken");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && ce && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  a_read_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready high with read pending");
  a_resp_code_legal: assert property ((s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    and (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})) else $error("illegal response code");
  a_error_reads_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_commit_reopens: assert property ($rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("write channels closed after commit");
endmodule
`default_nettype wire
